//--- pdt_cpu_model.sv
// cpu side model of the data-space bus for the prescaled down timer
// assumes strobes are single-cycle pulses changed at the falling edge
`timescale 1ns/10ps
module pdt_cpu_model
	import pdt_pkg::*;
(
	input wire logic clk,
	output logic [7:0] cpu_addr,
	output logic cpu_wr_en,
	output logic [7:0] cpu_wdata,
	output logic cpu_rd_en,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rd_valid
);
	initial
	begin
		cpu_addr = 8'h00;
		cpu_wr_en = 1'h0;
		cpu_wdata = 8'h00;
		cpu_rd_en = 1'h0;
	end

	// plain stores only; a read-modify-write is two calls made on purpose
	task automatic wr(input logic [7:0] a,
		input logic [7:0] d);
		@(negedge clk);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr_en = 1'h1;
		@(negedge clk);
		cpu_wr_en = 1'h0;
		// released data must not keep showing the last value
		cpu_wdata = ~d;
	endtask : wr

	// answer is fixed one cycle after the strobe, so no wait loop
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk);
		cpu_addr = a;
		cpu_rd_en = 1'h1;
		@(negedge clk);
		cpu_rd_en = 1'h0;
		v = cpu_rd_valid;
		d = cpu_rdata;
	endtask : rd
endmodule : pdt_cpu_model

//--- pdt_pin_if.sv
// carries the cleaned timer pin level and its rising edge pulse
// assumes both ends run on the same oscillator clock
`timescale 1ns/10ps
interface pdt_pin_if;
	logic level;
	logic rise;
	modport front (output level, output rise);
	modport core (input level, input rise);
endinterface : pdt_pin_if

//--- pdt_pin_sync.sv
// three stage synchroniser and edge finder for the timer pin input
// assumes the pin changes slower than a few oscillator cycles
`timescale 1ns/10ps
module pdt_pin_sync
	import pdt_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic pin_i,
	pdt_pin_if.front pin
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic rise_reg;

	always_ff @(posedge clk)
	begin
		s1_reg <= pin_i;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// only stages two and three judge a change; stage one is metastable
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// follows the pin so release brings no false edge
			level_reg <= s3_reg;
			rise_reg <= 1'b0;
		end
		else
		begin
			rise_reg <= 1'b0;
			if (s2_reg == s3_reg && s3_reg != level_reg)
			begin
				level_reg <= s3_reg;
				rise_reg <= s3_reg;
			end
		end
	end

	assign pin.level = level_reg;
	assign pin.rise = rise_reg;

	property p_rise_once;
		@(posedge clk) disable iff (srst)
		pin.rise |-> pin.level && !$past(pin.level);
	endproperty
	a_rise_once: assert property (p_rise_once)
		else $error("pin rise without a low to high step");
endmodule : pdt_pin_sync

//--- pdt_pkg.sv
// constants shared by the prescaled down timer and its pin front end
// assumes one oscillator clock and a byte-wide data-space bus from the cpu
// Notes on behaviour
// - down counter drops by one on each rising edge of the prescaler tap
// - control bits 2:0 pick the tap, divide by 1 up to 128
// - control bit 5 sets pin direction: 0 input, 1 driven output
// - input mode: prescaler counts each rising edge seen on the pin
// - output mode: prescaler counts the internal sync pulse, one per 48
// - output mode: flag rising edge loads control bit 4 into pin latch
// - counter reaching zero sets the flag in control bit 7
// - writing zero to the counter or a one to control bit 7 sets flag
// - reading control while the flag reads one clears the flag
// - read-modify-write clears then restores flag, giving an extra edge
// - reset: counter and prescaler all ones, control zero, latch high
// - a counter write beats a coincident decrement to zero; no flag then
// - run bit 3 low holds prescaler at all ones and freezes counter
// - prescaler and counter are read/write locations, prescaler first
package pdt_pkg;
	localparam logic [7:0] PRESCALER_VALUE_ADDR = 8'hFD;
	localparam logic [7:0] TIMER_DOWN_COUNT_ADDR = 8'hFE;
	localparam logic [7:0] TIMER_STATUS_CONTROL_ADDR = 8'h09;
	localparam logic [7:0] PRESCALER_RESET = 8'hFF;
	localparam logic [7:0] DOWN_COUNT_RESET = 8'hFF;
	localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam int ZERO_FLAG_BIT = 7;
	localparam int DIRECTION_BIT = 5;
	localparam int OUT_VALUE_BIT = 4;
	localparam int RUN_N_BIT = 3;
	localparam int DIV_SEL_LSB = 0;
	localparam int DIV_SEL_MSB = 2;
	localparam int SYNC_DIVIDE = 48;
	localparam logic [5:0] SYNC_LAST = 6'(SYNC_DIVIDE - 1);
	localparam logic [5:0] SYNC_ZERO = 6'h00;
	localparam logic [5:0] SYNC_ONE = 6'h01;
endpackage : pdt_pkg

//--- pdt_timer.sv
// prescaled 8-bit down timer with status/control byte and timer pin
// assumes cpu strobes are single-cycle and synchronous to clk
`timescale 1ns/10ps
module pdt_timer
	import pdt_pkg::*;
#(
	parameter int SYNC_DIV = SYNC_DIVIDE
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] cpu_addr,
	input wire logic cpu_wr_en,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_rd_en,
	output logic [7:0] cpu_rdata,
	output logic cpu_rd_valid,
	input wire logic timer_pin_i,
	output logic timer_pin_o,
	output logic timer_pin_oe
);
	localparam logic [5:0] SYNC_END = 6'(SYNC_DIV - 1);

	pdt_pin_if pin_bus ();

	logic [7:0] prescaler_value_reg;
	logic [7:0] timer_down_count_reg;
	logic count_reached_zero_reg;
	logic count_reached_zero_next;
	logic pin_direction_select_reg;
	logic out_value_reg;
	logic prescaler_run_n_reg;
	logic [2:0] divide_select_reg;
	logic pin_latch_reg;
	logic [5:0] sync_cnt_reg;
	logic sync_pulse_reg;
	logic [7:0] cpu_rdata_reg;
	logic cpu_rd_valid_reg;

	logic wr_prescaler;
	logic wr_count;
	logic wr_control;
	logic rd_control;
	logic presc_tick;
	logic count_dec;
	logic zero_evt;
	logic flag_set;
	logic flag_clr;
	logic dir_next;
	logic dout_next;

	// true when the tap output rises on this prescaler decrement
	function automatic logic tap_rises(input logic [7:0] pre,
		input logic [2:0] sel);
		logic [7:0] mask;
		mask = (BYTE_ONE << sel) - BYTE_ONE;
		return (pre & mask) == BYTE_ZERO;
	endfunction : tap_rises

	pdt_pin_sync u_pin_sync (
		.clk(clk),
		.srst(srst),
		.pin_i(timer_pin_i),
		.pin(pin_bus.front)
	);

	assign wr_prescaler = cpu_wr_en
		&& cpu_addr == PRESCALER_VALUE_ADDR;
	assign wr_count = cpu_wr_en
		&& cpu_addr == TIMER_DOWN_COUNT_ADDR;
	assign wr_control = cpu_wr_en && cpu_addr == TIMER_STATUS_CONTROL_ADDR;
	assign rd_control = cpu_rd_en && cpu_addr == TIMER_STATUS_CONTROL_ADDR;

	// source of prescaler clock follows the pin direction
	assign presc_tick = pin_direction_select_reg ? sync_pulse_reg
		: pin_bus.rise;

	assign count_dec = !prescaler_run_n_reg ? 1'b0
		: presc_tick && tap_rises(prescaler_value_reg,
		divide_select_reg);

	// a coincident counter or prescaler write suppresses the timeout
	assign zero_evt = count_dec && timer_down_count_reg == BYTE_ONE
		&& !wr_count && !wr_prescaler;

	assign flag_set = zero_evt
		|| (wr_count && cpu_wdata == BYTE_ZERO)
		|| (wr_control && cpu_wdata[ZERO_FLAG_BIT]);
	assign flag_clr = rd_control && count_reached_zero_reg;

	// set wins over the read clear; rmw read then write re-raises the flag
	always_comb
	begin
		count_reached_zero_next = count_reached_zero_reg;
		if (flag_set)
			count_reached_zero_next = 1'b1;
		else if (flag_clr)
			count_reached_zero_next = 1'b0;
	end

	assign dir_next = wr_control ? cpu_wdata[DIRECTION_BIT]
		: pin_direction_select_reg;
	assign dout_next = wr_control ? cpu_wdata[OUT_VALUE_BIT] : out_value_reg;

	always_ff @(posedge clk)
	begin
		if (srst || sync_cnt_reg == SYNC_END)
			sync_cnt_reg <= SYNC_ZERO;
		else
			sync_cnt_reg <= sync_cnt_reg + SYNC_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			sync_pulse_reg <= 1'b0;
		else
			sync_pulse_reg <= sync_cnt_reg == SYNC_END;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			prescaler_value_reg <= PRESCALER_RESET;
		else if (wr_prescaler)
			prescaler_value_reg <= cpu_wdata;
		else if (!prescaler_run_n_reg)
			prescaler_value_reg <= PRESCALER_RESET;
		else if (presc_tick)
			prescaler_value_reg <= prescaler_value_reg - BYTE_ONE;
	end

	// wraps through all ones after zero
	always_ff @(posedge clk)
	begin
		if (srst)
			timer_down_count_reg <= DOWN_COUNT_RESET;
		else if (wr_count)
			timer_down_count_reg <= cpu_wdata;
		else if (count_dec)
			timer_down_count_reg <= timer_down_count_reg - BYTE_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			count_reached_zero_reg <= STATUS_CONTROL_RESET[ZERO_FLAG_BIT];
		else
			count_reached_zero_reg <= count_reached_zero_next;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin_direction_select_reg <= STATUS_CONTROL_RESET[DIRECTION_BIT];
			out_value_reg <= STATUS_CONTROL_RESET[OUT_VALUE_BIT];
			prescaler_run_n_reg <= STATUS_CONTROL_RESET[RUN_N_BIT];
			divide_select_reg <= STATUS_CONTROL_RESET[DIV_SEL_MSB:DIV_SEL_LSB];
		end
		else if (wr_control)
		begin
			pin_direction_select_reg <= cpu_wdata[DIRECTION_BIT];
			out_value_reg <= cpu_wdata[OUT_VALUE_BIT];
			prescaler_run_n_reg <= cpu_wdata[RUN_N_BIT];
			divide_select_reg <= cpu_wdata[DIV_SEL_MSB:DIV_SEL_LSB];
		end
	end

	// uses the freshly written out value so one store can arm and fire
	always_ff @(posedge clk)
	begin
		if (srst)
			pin_latch_reg <= 1'b1;
		else if (dir_next && !count_reached_zero_reg
			&& count_reached_zero_next)
			pin_latch_reg <= dout_next;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer_pin_o <= 1'b1;
			timer_pin_oe <= 1'b0;
		end
		else
		begin
			timer_pin_o <= pin_latch_reg;
			timer_pin_oe <= pin_direction_select_reg;
		end
	end

	// unmapped addresses read zero; bit 6 unused reads zero
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cpu_rdata_reg <= BYTE_ZERO;
			cpu_rd_valid_reg <= 1'b0;
		end
		else
		begin
			cpu_rd_valid_reg <= cpu_rd_en;
			if (!cpu_rd_en)
				cpu_rdata_reg <= BYTE_ZERO;
			else if (cpu_addr == PRESCALER_VALUE_ADDR)
				cpu_rdata_reg <= prescaler_value_reg;
			else if (cpu_addr == TIMER_DOWN_COUNT_ADDR)
				cpu_rdata_reg <= timer_down_count_reg;
			else if (cpu_addr == TIMER_STATUS_CONTROL_ADDR)
				cpu_rdata_reg <= {count_reached_zero_reg, 1'b0,
					pin_direction_select_reg, out_value_reg,
					prescaler_run_n_reg, divide_select_reg};
			else
				cpu_rdata_reg <= BYTE_ZERO;
		end
	end

	assign cpu_rdata = cpu_rdata_reg;
	assign cpu_rd_valid = cpu_rd_valid_reg;

	sequence s_rd_flag_set;
		rd_control && count_reached_zero_reg && !flag_set;
	endsequence

	sequence s_flag_low;
		!count_reached_zero_reg;
	endsequence

	sequence s_zero_rise;
		!count_reached_zero_reg && count_reached_zero_next;
	endsequence

	property p_count_dec;
		@(posedge clk) disable iff (srst)
		count_dec && !wr_count |=>
		timer_down_count_reg == $past(timer_down_count_reg) - BYTE_ONE;
	endproperty
	a_count_dec: assert property (p_count_dec)
		else $error("counter did not drop on tap edge");

	property p_count_hold;
		@(posedge clk) disable iff (srst)
		!wr_count && !(presc_tick && tap_rises(prescaler_value_reg,
		divide_select_reg)) |=> $stable(timer_down_count_reg);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("counter moved without a tap edge");

	property p_freeze;
		@(posedge clk) disable iff (srst)
		!prescaler_run_n_reg && !wr_prescaler && !wr_count |=>
		prescaler_value_reg == PRESCALER_RESET
		&& $stable(timer_down_count_reg);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("prescaler not held while stopped");

	property p_sync_gap;
		@(posedge clk) disable iff (srst)
		sync_pulse_reg |=> !sync_pulse_reg [*8];
	endproperty
	a_sync_gap: assert property (p_sync_gap)
		else $error("sync pulses too close");

	property p_sync_period;
		@(posedge clk) disable iff (srst)
		sync_pulse_reg |=> ##[1:47] sync_pulse_reg;
	endproperty
	a_sync_period: assert property (p_sync_period)
		else $error("sync pulse missing");

	property p_zero_set;
		@(posedge clk) disable iff (srst)
		zero_evt |=> count_reached_zero_reg && timer_down_count_reg == BYTE_ZERO;
	endproperty
	a_zero_set: assert property (p_zero_set)
		else $error("timeout did not raise flag");

	property p_write_zero;
		@(posedge clk) disable iff (srst)
		wr_count && cpu_wdata == BYTE_ZERO |=> count_reached_zero_reg;
	endproperty
	a_write_zero: assert property (p_write_zero)
		else $error("zero write did not raise flag");

	property p_read_clear;
		@(posedge clk) disable iff (srst)
		s_rd_flag_set |=> s_flag_low ##1 1'b1;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("read did not clear flag");

	property p_write_wins;
		@(posedge clk) disable iff (srst)
		count_dec && timer_down_count_reg == BYTE_ONE && wr_count
		&& cpu_wdata != BYTE_ZERO && !count_reached_zero_reg
		&& !(wr_control && cpu_wdata[ZERO_FLAG_BIT])
		|=> !count_reached_zero_reg;
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("flag set despite coincident write");

	property p_latch_load;
		@(posedge clk) disable iff (srst)
		s_zero_rise and dir_next |=> pin_latch_reg == $past(dout_next)
		##1 timer_pin_o == $past(pin_latch_reg);
	endproperty
	a_latch_load: assert property (p_latch_load)
		else $error("pin latch not loaded on flag edge");

	property p_direction;
		@(posedge clk) disable iff (srst)
		1'b1 |=> timer_pin_oe == $past(pin_direction_select_reg);
	endproperty
	a_direction: assert property (p_direction)
		else $error("pin enable disagrees with direction");

	property p_reset;
		@(posedge clk)
		srst |=> timer_down_count_reg == DOWN_COUNT_RESET
		&& prescaler_value_reg == PRESCALER_RESET && pin_latch_reg
		&& !count_reached_zero_reg && !prescaler_run_n_reg
		&& !timer_pin_oe && timer_pin_o;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset values wrong");

	property p_read_count;
		@(posedge clk) disable iff (srst)
		cpu_rd_en && cpu_addr == TIMER_DOWN_COUNT_ADDR |=>
		cpu_rd_valid && cpu_rdata == $past(timer_down_count_reg);
	endproperty
	a_read_count: assert property (p_read_count)
		else $error("counter read wrong");
endmodule : pdt_timer

//--- pdt_timer_tb.sv
// self-checking bench for the prescaled down timer
// assumes the cpu model drives the bus and the bench drives the pin
`timescale 1ns/10ps
module pdt_timer_tb
	import pdt_pkg::*;
;
	logic clk;
	logic srst;
	logic [7:0] cpu_addr;
	logic cpu_wr_en;
	logic [7:0] cpu_wdata;
	logic cpu_rd_en;
	logic [7:0] cpu_rdata;
	logic cpu_rd_valid;
	logic timer_pin_o;
	logic timer_pin_oe;
	logic tb_pin;
	wire logic pin_level;
	int bad_count;
	int comparisons;
	localparam logic [7:0] CTL = TIMER_STATUS_CONTROL_ADDR;
	localparam logic [7:0] CNT = TIMER_DOWN_COUNT_ADDR;
	localparam logic [7:0] PRE = PRESCALER_VALUE_ADDR;

	// the pin wire: block drives it when enabled, else the bench
	assign pin_level = timer_pin_oe ? timer_pin_o : tb_pin;

	pdt_timer #(.SYNC_DIV(SYNC_DIVIDE)) dut_u (.clk(clk), .srst(srst),
		.cpu_addr(cpu_addr), .cpu_wr_en(cpu_wr_en), .cpu_wdata(cpu_wdata),
		.cpu_rd_en(cpu_rd_en), .cpu_rdata(cpu_rdata),
		.cpu_rd_valid(cpu_rd_valid), .timer_pin_i(pin_level),
		.timer_pin_o(timer_pin_o), .timer_pin_oe(timer_pin_oe));

	pdt_cpu_model cpu_u (.clk(clk), .cpu_addr(cpu_addr),
		.cpu_wr_en(cpu_wr_en), .cpu_wdata(cpu_wdata), .cpu_rd_en(cpu_rd_en),
		.cpu_rdata(cpu_rdata), .cpu_rd_valid(cpu_rd_valid));

	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		logic [7:0] d;
		logic v;
		cpu_u.rd(a, d, v);
		chk({what, " valid"}, 8'h01, {7'h00, v});
		chk(what, exp, d);
	endtask : rdchk

	// just slower than clk over 48 (50 cycles a pulse), as an outside source must be
	task automatic pulse;
		tb_pin = 1'h0;
		repeat (25) @(negedge clk);
		tb_pin = 1'h1;
		repeat (25) @(negedge clk);
	endtask : pulse

	task automatic do_reset;
		srst = 1'h1;
		repeat (16) @(negedge clk);
		srst = 1'h0;
	endtask : do_reset

	task automatic t_reset;
		chk("pin out", 8'h01, {7'h00, timer_pin_o});
		chk("pin enable", 8'h00, {7'h00, timer_pin_oe});
		rdchk(PRE, 8'hFF, "prescaler");
		rdchk(CNT, 8'hFF, "counter");
		rdchk(CTL, 8'h00, "control");
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs;
		cpu_u.wr(PRE, 8'h5A);
		rdchk(PRE, 8'hFF, "held prescaler");
		cpu_u.wr(CTL, 8'h08);
		cpu_u.wr(PRE, 8'h5A);
		rdchk(PRE, 8'h5A, "prescaler");
		cpu_u.wr(CNT, 8'hA5);
		rdchk(CNT, 8'hA5, "counter");
		cpu_u.wr(8'h40, 8'h77);
		rdchk(8'h40, 8'h00, "unmapped");
		$display("test registers done");
	endtask : t_regs

	// every tap: 3 counter steps need exactly 3 << sel pin edges
	task automatic t_divide;
		for (int s = 0; s < 8; s++)
		begin
			cpu_u.wr(CTL, 8'h00);
			cpu_u.wr(CNT, 8'h10);
			cpu_u.wr(CTL, 8'h08 | 8'(s));
			repeat (3 << s) pulse();
			repeat (8) @(negedge clk);
			rdchk(CNT, 8'h0D, "divided count");
		end
		cpu_u.wr(CTL, 8'h00);
		repeat (4) pulse();
		rdchk(CNT, 8'h0D, "frozen count");
		rdchk(PRE, 8'hFF, "held prescaler");
		$display("test divide done");
	endtask : t_divide

	task automatic t_out;
		int n;
		cpu_u.wr(CNT, 8'h03);
		cpu_u.wr(CTL, 8'h28);
		n = 0;
		while (timer_pin_o !== 1'h0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		// three sync ticks of 48 cycles, first one of unknown phase
		chk("tick count", 8'h01, {7'h00, n >= 96 && n <= 150});
		// a pin that never moves ends the run here
		if (n >= 200)
			results();
		chk("pin enable", 8'h01, {7'h00, timer_pin_oe});
		rdchk(CNT, 8'h00, "count at zero");
		rdchk(CTL, 8'hA8, "flag set");
		rdchk(CTL, 8'h28, "flag cleared");
		repeat (40) @(negedge clk);
		rdchk(CNT, 8'hFF, "wrapped count");
		$display("test output mode done");
	endtask : t_out

	task automatic t_flag;
		cpu_u.wr(CTL, 8'h00);
		cpu_u.wr(CNT, 8'h00);
		rdchk(CTL, 8'h80, "flag by zero write");
		rdchk(CTL, 8'h00, "flag cleared");
		cpu_u.wr(CTL, 8'hB0);
		@(negedge clk);
		chk("latched one", 8'h01, {7'h00, timer_pin_o});
		// read then write back with the out value dropped
		rdchk(CTL, 8'hB0, "rmw read");
		cpu_u.wr(CTL, 8'hA0);
		@(negedge clk);
		chk("rmw edge", 8'h00, {7'h00, timer_pin_o});
		rdchk(CTL, 8'hA0, "rmw flag");
		$display("test flag done");
	endtask : t_flag

	// counter write aimed at the edge that would time out
	task automatic t_race;
		tb_pin = 1'h0;
		cpu_u.wr(CTL, 8'h08);
		cpu_u.wr(CNT, 8'h01);
		repeat (8) @(negedge clk);
		// the pin rise reaches the counter four edges later
		tb_pin = 1'h1;
		repeat (3) @(negedge clk);
		cpu_u.wr(CNT, 8'h44);
		repeat (8) @(negedge clk);
		rdchk(CTL, 8'h08, "flag after race");
		rdchk(CNT, 8'h44, "count after race");
		$display("test write race done");
	endtask : t_race

	initial
	begin
		srst = 1'h1;
		tb_pin = 1'h0;
		bad_count = 0;
		comparisons = 0;
		do_reset();
		t_reset();
		t_regs();
		t_divide();
		t_out();
		t_flag();
		t_race();
		// second reset mid-run, with pin driven high by the bench and count at 44
		do_reset();
		t_reset();
		results();
	end

	// cuts a hang short
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		results();
	end
endmodule : pdt_timer_tb
